// *** hsts_pkg.sv ***
// Constants, timing selections and decode functions for the hot-swap timing sequencer
package hsts_pkg;

  // ==========================================================================
  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 23;
  localparam int unsigned DIV_W = 16;

  // ==========================================================================
  // Fault clear and serial noise filter
  localparam int unsigned CBRST_MIN_NS = 200;
  localparam int unsigned CBRST_CYC = (CBRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NOISE_MAX_NS = 100;
  localparam int unsigned NOISE_CYC = NOISE_MAX_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Selectable times in microseconds
  localparam int unsigned OC_T0_US = 5;
  localparam int unsigned OC_T1_US = 50;
  localparam int unsigned OC_T2_US = 150;
  localparam int unsigned OC_T3_US = 400;
  localparam int unsigned PG_T0_US = 50;
  localparam int unsigned PG_T1_US = 250;
  localparam int unsigned PG_T2_US = 500;
  localparam int unsigned PG_T3_US = 1000;
  localparam int unsigned PG_T4_US = 5000;
  localparam int unsigned PG_T5_US = 20000;
  localparam int unsigned PG_T6_US = 80000;
  localparam int unsigned PG_T7_US = 160000;
  localparam int unsigned CYC_T0_US = 2500000;
  localparam int unsigned CYC_T1_US = 5000000;
  localparam int unsigned UV_T1_US = 5000;
  localparam int unsigned UV_T2_US = 80000;
  localparam int unsigned UV_T3_US = 160000;
  localparam int unsigned PD_T0_US = 500;
  localparam int unsigned PD_T1_US = 5000;
  localparam int unsigned PD_T2_US = 80000;
  localparam int unsigned PD_T3_US = 160000;

  // ==========================================================================
  // Selection defaults after reset
  localparam logic [1:0] OC_SEL_DEF = 2'h1;
  localparam logic [2:0] PG_SEL_DEF = 3'h4;
  localparam logic CYC_SEL_DEF = 1'b0;
  localparam logic [1:0] UV_SEL_DEF = 2'h0;
  localparam logic [1:0] PD_SEL_DEF = 2'h2;

  typedef enum logic [1:0] {
    HSTS_WAIT = 2'b00,
    HSTS_RAMP = 2'b01,
    HSTS_ON = 2'b10,
    HSTS_FAULT = 2'b11
  } hsts_state_t;

  // ==========================================================================
  // Terminal count decode
  function automatic logic [CNT_W-1:0] oc_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: oc_ticks = CNT_W'(OC_T0_US);
      2'h1: oc_ticks = CNT_W'(OC_T1_US);
      2'h2: oc_ticks = CNT_W'(OC_T2_US);
      default: oc_ticks = CNT_W'(OC_T3_US);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] pg_ticks(input logic [2:0] sel);
    case (sel)
      3'h0: pg_ticks = CNT_W'(PG_T0_US);
      3'h1: pg_ticks = CNT_W'(PG_T1_US);
      3'h2: pg_ticks = CNT_W'(PG_T2_US);
      3'h3: pg_ticks = CNT_W'(PG_T3_US);
      3'h4: pg_ticks = CNT_W'(PG_T4_US);
      3'h5: pg_ticks = CNT_W'(PG_T5_US);
      3'h6: pg_ticks = CNT_W'(PG_T6_US);
      default: pg_ticks = CNT_W'(PG_T7_US);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] cyc_ticks(input logic sel);
    cyc_ticks = sel ? CNT_W'(CYC_T1_US) : CNT_W'(CYC_T0_US);
  endfunction

  function automatic logic [CNT_W-1:0] uv_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: uv_ticks = '0;
      2'h1: uv_ticks = CNT_W'(UV_T1_US);
      2'h2: uv_ticks = CNT_W'(UV_T2_US);
      default: uv_ticks = CNT_W'(UV_T3_US);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] pd_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: pd_ticks = CNT_W'(PD_T0_US);
      2'h1: pd_ticks = CNT_W'(PD_T1_US);
      2'h2: pd_ticks = CNT_W'(PD_T2_US);
      default: pd_ticks = CNT_W'(PD_T3_US);
    endcase
  endfunction

endpackage

// *** hsts_twi_frame.sv ***
// Noise filter and bit framing of the two-wire programming port
module hsts_twi_frame (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic tx_bit,
  input wire logic tx_en,
  output logic sda_out,
  output logic sda_oe_n,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic start_seen,
  output logic stop_seen
);

  logic [1:0] scl_hist_r;
  logic [1:0] sda_hist_r;
  logic scl_f_r;
  logic sda_f_r;

  // Level passes only once stable longer than the noise window
  function automatic logic filt(input logic in, input logic [1:0] hist, input logic cur);
    filt = (in == hist[0] && in == hist[1]) ? in : cur;
  endfunction

  // ==========================================================================
  // Noise filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_hist_r <= 2'h3;
      sda_hist_r <= 2'h3;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_hist_r <= {scl_hist_r[0], scl_in};
      sda_hist_r <= {sda_hist_r[0], sda_in};
      scl_f_r <= filt(scl_in, scl_hist_r, scl_f_r);
      sda_f_r <= filt(sda_in, sda_hist_r, sda_f_r);
    end
  end

  // ==========================================================================
  // Framing
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
      rx_bit_valid <= scl_f_r && !scl_d_r;
      if (scl_f_r && !scl_d_r) begin
        rx_bit <= sda_f_r;
      end
      start_seen <= scl_f_r && scl_d_r && sda_d_r && !sda_f_r;
      stop_seen <= scl_f_r && scl_d_r && !sda_d_r && sda_f_r;
    end
  end

  // Drive changes only while the filtered clock is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (!scl_f_r) begin
      sda_oe_n <= !(tx_en && !tx_bit);
    end
  end

  // ==========================================================================
  // Checks
  chk_noise_reject: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(scl_f_r) |-> (scl_hist_r[0] == scl_f_r && $past(scl_hist_r[0]) == scl_f_r))
    else $error("serial clock filter passed a short pulse");

  chk_one_bit: assert property (@(posedge clk) disable iff (!rst_n)
    rx_bit_valid |=> !rx_bit_valid)
    else $error("more than one bit per clock pulse");

  chk_sda_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (scl_f_r && $past(scl_f_r)) |-> $stable(sda_oe_n))
    else $error("driven data changed while clock high");

endmodule // hsts_twi_frame

// *** hsts_sequencer.sv ***
// Hot-swap timing sequencer: filters, debounce, breaker and power-good cascade
module hsts_sequencer #(
  parameter int unsigned TICK_CYCLES = hsts_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_load,
  input wire logic [1:0] overcurrent_filter_time,
  input wire logic [2:0] power_ok_step_delay,
  input wire logic breaker_retry_period,
  input wire logic [1:0] undervolt_filter_time,
  input wire logic [1:0] insertion_debounce_time,
  input wire logic breaker_cycle_mode,
  input wire logic overcurrent_in,
  input wire logic supply_ok,
  input wire logic insertion_detect_a_n,
  input wire logic insertion_detect_b_n,
  input wire logic breaker_fault_clear,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic tx_bit,
  input wire logic tx_en,
  output logic power_ok_out_first,
  output logic power_ok_out_second,
  output logic power_ok_out_third,
  output logic power_ok_out_last,
  output logic gate_enable,
  output logic breaker_tripped,
  output logic sda_out,
  output logic sda_oe_n,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic start_seen,
  output logic stop_seen
);

  localparam int unsigned CW = hsts_pkg::CNT_W;
  localparam int unsigned DW = hsts_pkg::DIV_W;
  localparam logic [DW-1:0] TICK_LAST = DW'(TICK_CYCLES - 1);
  localparam logic [2:0] CLR_LAST = 3'(hsts_pkg::CBRST_CYC - 1);

  // ==========================================================================
  // Timebase
  logic [DW-1:0] div_r;
  logic tick_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TICK_LAST);
      div_r <= (div_r == TICK_LAST) ? '0 : div_r + 1'b1;
    end
  end

  // ==========================================================================
  // Configuration
  logic [1:0] oc_sel_r;
  logic [2:0] pg_sel_r;
  logic cyc_sel_r;
  logic [1:0] uv_sel_r;
  logic [1:0] pd_sel_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_sel_r <= hsts_pkg::OC_SEL_DEF;
      pg_sel_r <= hsts_pkg::PG_SEL_DEF;
      cyc_sel_r <= hsts_pkg::CYC_SEL_DEF;
      uv_sel_r <= hsts_pkg::UV_SEL_DEF;
      pd_sel_r <= hsts_pkg::PD_SEL_DEF;
    end else if (cfg_load) begin
      oc_sel_r <= overcurrent_filter_time;
      pg_sel_r <= power_ok_step_delay;
      cyc_sel_r <= breaker_retry_period;
      uv_sel_r <= undervolt_filter_time;
      pd_sel_r <= insertion_debounce_time;
    end
  end

  logic [CW-1:0] oc_term;
  logic [CW-1:0] pg_term;
  logic [CW-1:0] cyc_term;
  logic [CW-1:0] uv_term;
  logic [CW-1:0] pd_term;
  assign oc_term = hsts_pkg::oc_ticks(oc_sel_r);
  assign pg_term = hsts_pkg::pg_ticks(pg_sel_r);
  assign cyc_term = hsts_pkg::cyc_ticks(cyc_sel_r);
  assign uv_term = hsts_pkg::uv_ticks(uv_sel_r);
  assign pd_term = hsts_pkg::pd_ticks(pd_sel_r);

  // ==========================================================================
  // Filters
  logic ins_ok;
  logic [CW-1:0] pd_cnt_r;
  logic [CW-1:0] uv_cnt_r;
  logic [CW-1:0] oc_cnt_r;
  logic pd_done;
  logic uv_done;
  logic oc_trip;
  assign ins_ok = !insertion_detect_a_n && !insertion_detect_b_n;
  assign pd_done = ins_ok && (pd_cnt_r >= pd_term);
  assign uv_done = supply_ok && (uv_cnt_r >= uv_term);
  assign oc_trip = overcurrent_in && (oc_cnt_r >= oc_term);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_cnt_r <= '0;
      uv_cnt_r <= '0;
      oc_cnt_r <= '0;
    end else begin
      if (!ins_ok) pd_cnt_r <= '0;
      else if (tick_r && !pd_done) pd_cnt_r <= pd_cnt_r + 1'b1;
      if (!supply_ok) uv_cnt_r <= '0;
      else if (tick_r && !uv_done) uv_cnt_r <= uv_cnt_r + 1'b1;
      if (!overcurrent_in) oc_cnt_r <= '0;
      else if (tick_r && !oc_trip) oc_cnt_r <= oc_cnt_r + 1'b1;
    end
  end

  // Fault clear recognised only after the minimum width
  logic [2:0] clr_cnt_r;
  logic clr_hit;
  assign clr_hit = breaker_fault_clear && (clr_cnt_r == CLR_LAST);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt_r <= '0;
    end else if (!breaker_fault_clear) begin
      clr_cnt_r <= '0;
    end else if (clr_cnt_r != CLR_LAST) begin
      clr_cnt_r <= clr_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Sequencer
  hsts_pkg::hsts_state_t state_r;
  logic [CW-1:0] seq_cnt_r;
  logic [3:0] pg_r;
  logic step_done;
  logic retry_done;
  assign step_done = tick_r && (seq_cnt_r >= pg_term - 1'b1);
  assign retry_done = tick_r && (seq_cnt_r >= cyc_term - 1'b1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= hsts_pkg::HSTS_WAIT;
      seq_cnt_r <= '0;
      pg_r <= 4'h0;
      gate_enable <= 1'b0;
      breaker_tripped <= 1'b0;
    end else begin
      case (state_r)
        hsts_pkg::HSTS_WAIT: begin
          seq_cnt_r <= '0;
          if (pd_done && uv_done) begin
            state_r <= hsts_pkg::HSTS_RAMP;
            pg_r <= 4'h1;
            gate_enable <= 1'b1;
          end
        end
        hsts_pkg::HSTS_RAMP, hsts_pkg::HSTS_ON: begin
          if (oc_trip) begin
            state_r <= hsts_pkg::HSTS_FAULT;
            pg_r <= 4'h0;
            gate_enable <= 1'b0;
            breaker_tripped <= 1'b1;
            seq_cnt_r <= '0;
          end else if (!ins_ok || !supply_ok) begin
            state_r <= hsts_pkg::HSTS_WAIT;
            pg_r <= 4'h0;
            gate_enable <= 1'b0;
          end else if (state_r == hsts_pkg::HSTS_RAMP) begin
            if (step_done) begin
              seq_cnt_r <= '0;
              pg_r <= {pg_r[2:0], 1'b1};
              if (pg_r[2]) state_r <= hsts_pkg::HSTS_ON;
            end else if (tick_r) begin
              seq_cnt_r <= seq_cnt_r + 1'b1;
            end
          end
        end
        default: begin
          if (clr_hit || (breaker_cycle_mode && retry_done)) begin
            state_r <= hsts_pkg::HSTS_WAIT;
            breaker_tripped <= 1'b0;
            seq_cnt_r <= '0;
          end else if (tick_r) begin
            seq_cnt_r <= seq_cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ok_out_first <= 1'b0;
      power_ok_out_second <= 1'b0;
      power_ok_out_third <= 1'b0;
      power_ok_out_last <= 1'b0;
    end else begin
      power_ok_out_first <= pg_r[0];
      power_ok_out_second <= pg_r[1];
      power_ok_out_third <= pg_r[2];
      power_ok_out_last <= pg_r[3];
    end
  end

  // ==========================================================================
  // Two-wire port
  hsts_twi_frame u_twi (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .tx_bit(tx_bit),
    .tx_en(tx_en),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // ==========================================================================
  // Checks
  chk_oc_filter: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(breaker_tripped) |-> $past(oc_cnt_r) >= $past(oc_term))
    else $error("breaker tripped before filter time");

  chk_cascade_order: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(pg_r[1]) |-> pg_r[0]) and ($rose(pg_r[3]) |-> pg_r[2] && pg_r[1]))
    else $error("power-good out of order");

  chk_step_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pg_r[2]) |-> $past(seq_cnt_r) == $past(pg_term) - 1'b1 && $past(tick_r))
    else $error("power-good step delay wrong");

  chk_retry_period: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == hsts_pkg::HSTS_FAULT ##1 state_r == hsts_pkg::HSTS_WAIT && !$past(clr_hit))
    |-> $past(seq_cnt_r) >= $past(cyc_term) - 1'b1)
    else $error("breaker retry too early");

  chk_clear_width: assert property (@(posedge clk) disable iff (!rst_n)
    clr_hit |-> $past(breaker_fault_clear, 4) && $past(breaker_fault_clear, 1))
    else $error("short clear pulse accepted");

  chk_uv_filter: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pg_r[0]) |-> $past(uv_cnt_r) >= $past(uv_term) && $past(supply_ok))
    else $error("cascade before under-voltage filter");

  chk_pd_debounce: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pg_r[0]) |-> $past(pd_cnt_r) >= $past(pd_term) && $past(ins_ok))
    else $error("cascade before insertion debounce");

  chk_tick_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    tick_r |=> !tick_r || TICK_CYCLES == 1)
    else $error("timebase tick longer than one cycle");

endmodule // hsts_sequencer

// *** hsts_host_model.sv ***
// Two-wire host model driving the serial clock and open-drain data line
module hsts_host_model (
  input wire logic clk,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;

  // ==========================================================================
  // Line control
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start_cond();
    sda_low = 1'b1; // Data falls while clock high
    hold(HALF);
    scl = 1'b0;
    hold(HALF);
  endtask

  task automatic send_bit(input logic b);
    sda_low = ~b; // Data set only while clock low
    hold(HALF);
    scl = 1'b1; // One clock pulse per bit
    hold(HALF);
    scl = 1'b0;
    hold(HALF);
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b0; // Data rises while clock high
    hold(HALF);
  endtask

  task automatic glitch_scl(input int n);
    scl = ~scl; // Short noise pulse
    hold(n);
    scl = ~scl;
    hold(HALF);
  endtask

  task automatic glitch_sda(input int n);
    sda_low = ~sda_low; // Short noise pulse
    hold(n);
    sda_low = ~sda_low;
    hold(HALF);
  endtask
endmodule // hsts_host_model

// *** hot_swap_timing_sequencer_bench.sv ***
// Self-checking bench of the hot-swap timing sequencer
module hot_swap_timing_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  logic clk, rst_n, cfg_load, cyc_mode, oc_in, sup_ok, det_a_n, det_b_n, clr, cyc_sel;
  logic tx_bit, tx_en, mon_en, prev_oe;
  logic [1:0] oc_sel, uv_sel, pd_sel;
  logic [2:0] pg_sel;
  logic [7:0] rx_sh;
  logic pg1, pg2, pg3, pg4, gate_en, brk, sda_out, sda_oe_n, rx_bit, rx_valid, st_p, sp_p;
  logic host_scl, host_sda_low;
  wire logic sda_line = ~(host_sda_low | (~sda_oe_n & ~sda_out));
  wire logic [3:0] pg_vec = {pg4, pg3, pg2, pg1};
  int failures = 0, total_checks = 0, cycles = 0, hi_cnt = 0;
  int rx_cnt = 0, start_cnt = 0, stop_cnt = 0;
  int pg_tab[4] = '{hsts_pkg::PG_T0_US, hsts_pkg::PG_T1_US, hsts_pkg::PG_T2_US,
    hsts_pkg::PG_T3_US};
  int oc_tab[4] = '{hsts_pkg::OC_T0_US, hsts_pkg::OC_T1_US, hsts_pkg::OC_T2_US,
    hsts_pkg::OC_T3_US};

  hsts_sequencer #(.TICK_CYCLES(1)) dut (.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load),
    .overcurrent_filter_time(oc_sel), .power_ok_step_delay(pg_sel),
    .breaker_retry_period(cyc_sel), .undervolt_filter_time(uv_sel),
    .insertion_debounce_time(pd_sel), .breaker_cycle_mode(cyc_mode),
    .overcurrent_in(oc_in), .supply_ok(sup_ok), .insertion_detect_a_n(det_a_n),
    .insertion_detect_b_n(det_b_n), .breaker_fault_clear(clr), .scl_in(host_scl),
    .sda_in(sda_line), .tx_bit(tx_bit), .tx_en(tx_en), .power_ok_out_first(pg1),
    .power_ok_out_second(pg2), .power_ok_out_third(pg3), .power_ok_out_last(pg4),
    .gate_enable(gate_en), .breaker_tripped(brk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .rx_bit(rx_bit), .rx_bit_valid(rx_valid), .start_seen(st_p), .stop_seen(sp_p));

  hsts_host_model host (.clk(clk), .scl(host_scl), .sda_low(host_sda_low));

  // ==========================================================================
  // Clock, timeout and serial monitor
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  always @(negedge clk) begin
    if (mon_en && hi_cnt >= 5) check(sda_oe_n, prev_oe);
    hi_cnt = host_scl ? hi_cnt + 1 : 0;
    prev_oe = sda_oe_n;
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_sh = {rx_sh[6:0], rx_bit};
    end
    if (st_p === 1'b1) start_cnt++;
    if (sp_p === 1'b1) stop_cnt++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    total_checks++;
    if (seen !== expd) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, expd);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic configure(input logic [1:0] oc, input logic [2:0] pg, input logic [1:0] uv,
    input logic [1:0] pd);
    @(negedge clk);
    oc_sel = oc;
    pg_sel = pg;
    uv_sel = uv;
    pd_sel = pd;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
  endtask

  task automatic seat(input logic v);
    @(negedge clk);
    det_a_n = ~v;
    det_b_n = ~v;
    sup_ok = 1'b1;
    if (!v) repeat (5) @(negedge clk);
  endtask

  task automatic wait_pg(input int idx, input int limit, output int n);
    n = 0;
    while (pg_vec[idx] !== 1'b1 && n < limit) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic pulse_clear(input int n);
    clr = 1'b1; // Held high n cycles, valid from 200 ns
    repeat (n) @(negedge clk);
    clr = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults();
    int n;
    seat(1'b1);
    wait_pg(0, 2000, n);
    check(pg_vec, 4'h0);
    seat(1'b0);
  endtask

  task automatic t_cascade(input logic [2:0] pg, input logic [1:0] uv, input logic [1:0] pd);
    int n, first;
    configure(2'h0, pg, uv, pd);
    first = (uv == 2'h1) ? hsts_pkg::UV_T1_US :
      ((pd == 2'h1) ? hsts_pkg::PD_T1_US : hsts_pkg::PD_T0_US);
    seat(1'b1);
    wait_pg(0, first + 20, n);
    check(n >= first && n <= first + 4, 1);
    check(pg_vec, 4'h1);
    for (int i = 1; i < 4; i++) begin
      wait_pg(i, pg_tab[pg] + 10, n);
      check(n, pg_tab[pg]);
      check(pg_vec, (32'h2 << i) - 1);
    end
    check(gate_en, 1'b1);
    sup_ok = 1'b0;
    repeat (3) @(negedge clk);
    check(pg_vec, 4'h0);
    seat(1'b0);
  endtask

  task automatic t_overcurrent(input logic [1:0] s);
    int n, term;
    term = oc_tab[s];
    cyc_sel = (s == 2'h3);
    configure(s, 3'h0, 2'h0, 2'h0);
    cyc_mode = (s == 2'h3);
    seat(1'b1);
    wait_pg(3, 1000, n);
    oc_in = 1'b1;
    repeat (term - 3) @(negedge clk);
    oc_in = 1'b0;
    repeat (10) @(negedge clk);
    check(brk, 1'b0);
    oc_in = 1'b1;
    n = 0;
    while (brk !== 1'b1 && n < term + 10) begin
      @(negedge clk);
      n++;
    end
    check(n >= term - 1 && n <= term + 3, 1);
    repeat (3) @(negedge clk);
    check({gate_en, pg_vec}, 5'h00);
    oc_in = 1'b0;
    repeat (cyc_mode ? 1000 : 10) @(negedge clk);
    check(brk, 1'b1);
    pulse_clear(4);
    check(brk, 1'b1);
    pulse_clear(5);
    check(brk, 1'b0);
    cyc_mode = 1'b0;
    seat(1'b0);
  endtask

  task automatic t_serial();
    logic [7:0] byte_v;
    byte_v = 8'hA5;
    mon_en = 1'b1;
    host.glitch_sda(2);
    host.start_cond();
    host.glitch_scl(2);
    for (int i = 7; i >= 0; i--) host.send_bit(byte_v[i]);
    check(rx_cnt, 8);
    check(rx_sh, 8'hA5);
    check(start_cnt, 1);
    tx_bit = 1'b0;
    tx_en = 1'b1;
    host.send_bit(1'b1);
    check(rx_sh[0], 1'b0);
    tx_bit = 1'b1;
    host.send_bit(1'b1);
    check(rx_sh[0], 1'b1);
    tx_en = 1'b0;
    check(rx_cnt, 10);
    host.stop_cond();
    check(stop_cnt, 1);
    check(rx_cnt, 11);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {cfg_load, cyc_mode, oc_in, clr, tx_bit, tx_en, mon_en, cyc_sel} = '0;
    {sup_ok, det_a_n, det_b_n, prev_oe} = '1;
    {oc_sel, pg_sel, uv_sel, pd_sel} = '0;
    rx_sh = '0;
    repeat (3) @(negedge clk);
    check({sda_oe_n, sda_out, gate_en, brk, pg_vec}, 8'h80);
    rst_n = 1'b1;
    t_defaults();
    for (int p = 0; p < 4; p++) t_cascade(p[2:0], 2'h0, 2'h0);
    t_cascade(3'h0, 2'h1, 2'h0);
    t_cascade(3'h1, 2'h0, 2'h1);
    for (int s = 0; s < 4; s++) t_overcurrent(s[1:0]);
    t_serial();
    finish_test();
  end
endmodule // hot_swap_timing_sequencer_bench
